// File: rtl/int_enable_soft_watchdog_ctrl.sv
// Interrupt enable registers and software watchdog with an AHB-Lite register slave
//
// Notes on behaviour
// RULE1: global enable low blocks every source
// RULE2: enables for serial0, timers 0/1, ext0/1
// RULE3: enables for external interrupts 2 to 6
// RULE4: software sets refresh flag just before start
// RULE5: refresh flag self-clears after 12 cycles
// RULE6: start flag starts a stopped watchdog
// RULE7: start right after refresh reloads counter
// RULE8: start flag self-clears after 12 cycles
// RULE9: expiry sets status flag, requests internal reset
// RULE10: status survives internal reset, software clears it
// RULE11: prescale select adds divide-by-16 stage
// RULE12: refresh loads reload field into high byte
// RULE13: 16-bit counter, tick every 24/384 cycles
// RULE14: expiry when counter reaches 0x7CFF
// RULE15: running watchdog stops only on internal reset
// RULE16: missed window clears refresh flag, no reload
// RULE17: refresh clears the counter low byte
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module int_enable_soft_watchdog_ctrl
  import wd_int_pkg::*;
#(
  parameter int FAST_DIV = WD_FAST_DIV,
  parameter int SLOW_DIV = WD_SLOW_DIV
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic [NUM_SRC-1:0] srcReq,
  output logic      [NUM_SRC-1:0] srcGranted,
  output logic                    wdResetReq,
  output logic                    irq
);
  localparam int LW = $clog2(FLAG_LIFE_CYCLES);

  // Bus state
  logic        wrPend_q;
  logic [7:0]  wrIdx_q;
  logic [31:0] hrdata_q;
  logic [7:0]  addrIdx;
  logic        accValid;
  logic        rdAcc;
  logic        wrAt;

  // Register state
  logic                    globalEn_q;
  logic [EN0_SRC_W-1:0]    en0Src_q;
  logic [EN1_SRC_W-1:0]    en1Src_q;
  logic [PRI0_PRIO_W-1:0]  prio_q;
  logic                    prescaleSel_q;
  logic [RELOAD_VAL_W-1:0] reloadVal_q;
  logic                    refreshFlag_q;
  logic [LW-1:0]           refreshCnt_q;
  logic                    startFlag_q;
  logic [LW-1:0]           startCnt_q;
  wd_state_t               wdState_q;
  logic [15:0]             wdCount_q;
  logic                    wdResetReq_q;
  logic                    expiredStatus_q;
  logic [IRQ_W-1:0]        irqStatus_q;
  logic [IRQ_W-1:0]        irqMask_q;
  logic [NUM_SRC-1:0]      srcGranted_q;

  // Internal events
  logic             intRst;
  logic             refreshSet;
  logic             startSet;
  logic             reload;
  logic             startStopped;
  logic             expire;
  logic             missed;
  logic             tick;
  logic             wdRunning;
  logic             statusClr;
  logic [IRQ_W-1:0] irqEvents;
  logic [NUM_SRC-1:0] enVec;

  // Maps a byte address to a register index, IDX_NONE when unmapped
  function automatic logic [7:0] idxOf(input logic [31:0] a);
    logic [7:0] i;
    i = a[9:2];
    if (a[31:10] != 22'h0 || a[1:0] != 2'b00) begin
      return IDX_NONE;
    end else if (i == IDX_WD_RELOAD || i == IDX_INT_EN_PRI || i == IDX_INT_PRI0 || i == IDX_INT_EN_SEC) begin
      return i;
    end else if (i == IDX_IRQ_STATUS || i == IDX_IRQ_MASK || i == IDX_WD_COUNT) begin
      return i;
    end else begin
      return IDX_NONE;
    end
  endfunction

  // Address phase decode; single wait-free slave
  assign addrIdx   = idxOf(haddr);
  assign accValid  = hsel && htrans[1] && hready;
  assign rdAcc     = accValid && !hwrite;
  assign wrAt      = wrPend_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Capture a write address phase for use in the data phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrIdx_q  <= IDX_NONE;
    end else begin
      wrPend_q <= accValid && hwrite && addrIdx != IDX_NONE;
      wrIdx_q  <= addrIdx;
    end
  end

  // Read data registered at the address phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rdAcc) begin
      if (addrIdx == IDX_WD_RELOAD) begin
        hrdata_q <= {24'h00_0000, prescaleSel_q, reloadVal_q};
      end else if (addrIdx == IDX_INT_EN_PRI) begin
        hrdata_q <= {24'h00_0000, globalEn_q, refreshFlag_q, 1'b0, en0Src_q};
      end else if (addrIdx == IDX_INT_PRI0) begin
        hrdata_q <= {24'h00_0000, 1'b0, expiredStatus_q, prio_q};
      end else if (addrIdx == IDX_INT_EN_SEC) begin
        hrdata_q <= {24'h00_0000, 1'b0, startFlag_q, en1Src_q, 1'b0};
      end else if (addrIdx == IDX_IRQ_STATUS) begin
        hrdata_q <= {29'h0, irqStatus_q};
      end else if (addrIdx == IDX_IRQ_MASK) begin
        hrdata_q <= {29'h0, irqMask_q};
      end else if (addrIdx == IDX_WD_COUNT) begin
        hrdata_q <= {16'h0000, wdCount_q};
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  // Write strobes for the self-clearing flags; writing zero has no effect
  assign refreshSet   = wrAt && wrIdx_q == IDX_INT_EN_PRI && hwdata[EN0_REFRESH_BIT]; // [RULE4]
  assign startSet     = wrAt && wrIdx_q == IDX_INT_EN_SEC && hwdata[EN1_START_BIT];
  assign wdRunning    = wdState_q == WD_RUNNING;
  assign reload       = startSet && refreshFlag_q; // [RULE7]
  assign startStopped = startSet && !wdRunning;
  assign expire       = wdRunning && wdCount_q == WD_EXPIRE_VALUE; // [RULE14]
  assign missed       = refreshFlag_q && !startSet && refreshCnt_q == LW'(FLAG_LIFE_CYCLES - 1);
  assign intRst       = rst || wdResetReq_q;

  // Enable and configuration registers, cleared by any reset
  always_ff @(posedge ref_clk) begin
    if (intRst) begin
      globalEn_q    <= RST_INT_EN_PRI[EN0_GLOBAL_BIT];
      en0Src_q      <= RST_INT_EN_PRI[EN0_SRC_LSB +: EN0_SRC_W];
      en1Src_q      <= RST_INT_EN_SEC[EN1_SRC_LSB +: EN1_SRC_W];
      prio_q        <= RST_INT_PRI0[PRI0_PRIO_W-1:0];
      prescaleSel_q <= RST_WD_RELOAD[RELOAD_PSEL_BIT];
      reloadVal_q   <= RST_WD_RELOAD[RELOAD_VAL_W-1:0];
    end else if (wrAt) begin
      if (wrIdx_q == IDX_INT_EN_PRI) begin
        globalEn_q <= hwdata[EN0_GLOBAL_BIT];
        en0Src_q   <= hwdata[EN0_SRC_LSB +: EN0_SRC_W]; // [RULE2]
      end else if (wrIdx_q == IDX_INT_EN_SEC) begin
        en1Src_q <= hwdata[EN1_SRC_LSB +: EN1_SRC_W]; // [RULE3]
      end else if (wrIdx_q == IDX_INT_PRI0) begin
        prio_q <= hwdata[PRI0_PRIO_W-1:0];
      end else if (wrIdx_q == IDX_WD_RELOAD) begin
        prescaleSel_q <= hwdata[RELOAD_PSEL_BIT]; // [RULE11]
        reloadVal_q   <= hwdata[RELOAD_VAL_W-1:0];
      end
    end
  end

  // Refresh flag with its 12-cycle life; cleared early by a completed refresh
  always_ff @(posedge ref_clk) begin
    if (intRst) begin
      refreshFlag_q <= 1'b0;
      refreshCnt_q  <= '0;
    end else if (refreshSet) begin
      refreshFlag_q <= 1'b1;
      refreshCnt_q  <= '0;
    end else if (reload) begin
      refreshFlag_q <= 1'b0;
    end else if (refreshFlag_q) begin
      if (refreshCnt_q == LW'(FLAG_LIFE_CYCLES - 1)) begin
        refreshFlag_q <= 1'b0; // [RULE5] [RULE16]
      end else begin
        refreshCnt_q <= refreshCnt_q + LW'(1);
      end
    end
  end

  // Start flag with its 12-cycle life
  always_ff @(posedge ref_clk) begin
    if (intRst) begin
      startFlag_q <= 1'b0;
      startCnt_q  <= '0;
    end else if (startSet) begin
      startFlag_q <= 1'b1;
      startCnt_q  <= '0;
    end else if (startFlag_q) begin
      if (startCnt_q == LW'(FLAG_LIFE_CYCLES - 1)) begin
        startFlag_q <= 1'b0; // [RULE8]
      end else begin
        startCnt_q <= startCnt_q + LW'(1);
      end
    end
  end

  // Run state: only the internal reset stops a running watchdog
  always_ff @(posedge ref_clk) begin
    if (intRst) begin
      wdState_q <= WD_STOPPED; // [RULE15]
    end else begin
      case (wdState_q)
        WD_STOPPED: begin
          if (startSet) begin
            wdState_q <= WD_RUNNING; // [RULE6]
          end
        end
        WD_RUNNING: begin
          wdState_q <= WD_RUNNING; // [RULE15]
        end
        default: begin
          wdState_q <= WD_STOPPED;
        end
      endcase
    end
  end

  // Watchdog counter: reload sets high byte, clears low byte
  always_ff @(posedge ref_clk) begin
    if (intRst) begin
      wdCount_q <= RST_WD_COUNT;
    end else if (reload) begin
      wdCount_q <= {1'b0, reloadVal_q, 8'h00}; // [RULE12] [RULE17]
    end else if (tick && !expire) begin
      wdCount_q <= wdCount_q + 16'h0001; // [RULE13]
    end
  end

  // Prescaler, restarted on a reload or a fresh start
  wd_tick_gen #(
    .FAST_DIV (FAST_DIV),
    .SLOW_DIV (SLOW_DIV)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst     (intRst),
    .clear   (reload || startStopped),
    .run     (wdRunning),
    .slowSel (prescaleSel_q),
    .tick    (tick)
  );

  // Expiry pulse and status flag that survives the internal reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wdResetReq_q    <= 1'b0;
      expiredStatus_q <= RST_INT_PRI0[PRI0_STATUS_BIT];
    end else begin
      wdResetReq_q <= expire && !wdResetReq_q; // [RULE9]
      if (expire) begin
        expiredStatus_q <= 1'b1; // [RULE9] [RULE10]
      end else if (wrAt && wrIdx_q == IDX_INT_PRI0) begin
        expiredStatus_q <= hwdata[PRI0_STATUS_BIT]; // [RULE10]
      end
    end
  end
  assign wdResetReq = wdResetReq_q;

  // Sticky event bits, cleared by a status read; a new event wins
  assign irqEvents = {missed, reload, expire};
  assign statusClr = rdAcc && addrIdx == IDX_IRQ_STATUS;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqStatus_q <= RST_IRQ;
      irqMask_q   <= RST_IRQ;
    end else begin
      irqStatus_q <= (irqStatus_q & ~(statusClr ? {IRQ_W{1'b1}} : {IRQ_W{1'b0}})) | irqEvents;
      if (wrAt && wrIdx_q == IDX_IRQ_MASK) begin
        irqMask_q <= hwdata[IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irqStatus_q & irqMask_q);

  // Source gating by per-source and global enables
  assign enVec = {en1Src_q, en0Src_q} & {NUM_SRC{globalEn_q}}; // [RULE1] [RULE2] [RULE3]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      srcGranted_q <= '0;
    end else begin
      srcGranted_q <= srcReq & enVec;
    end
  end
  assign srcGranted = srcGranted_q;

  // Helper: age of the latest refresh and start writes, saturating
  logic [4:0] refreshAge_q;
  logic [4:0] startAge_q;
  logic       refreshClean_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      refreshAge_q   <= 5'h00;
      refreshClean_q <= 1'b0;
    end else if (refreshSet) begin
      refreshAge_q   <= 5'h01;
      refreshClean_q <= 1'b1;
    end else begin
      if (refreshAge_q != 5'h00 && refreshAge_q != 5'h1F) begin
        refreshAge_q <= refreshAge_q + 5'h01;
      end
      if (startSet || wdResetReq_q) begin
        refreshClean_q <= 1'b0; // Early clear by reload or reset is legal
      end
    end
  end

  // Helper: start write age, saturating
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      startAge_q <= 5'h00;
    end else if (startSet) begin
      startAge_q <= 5'h01;
    end else if (startAge_q != 5'h00 && startAge_q != 5'h1F) begin
      startAge_q <= startAge_q + 5'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  globalBlock_a: assert property (!globalEn_q |=> srcGranted == '0) // [RULE1]
    else $error("source granted while global enable low");
  primaryGate_a: assert property (1'b1 |=> srcGranted[4:0] == $past(srcReq[4:0] & en0Src_q & {5{globalEn_q}})) // [RULE2]
    else $error("primary source gating wrong");
  secondaryGate_a: assert property (1'b1 |=> srcGranted[9:5] == $past(srcReq[9:5] & en1Src_q & {5{globalEn_q}})) // [RULE3]
    else $error("external 2-6 gating wrong");
  refreshHeld_a: assert property (refreshClean_q && refreshAge_q inside {[1:FLAG_LIFE_CYCLES]} |-> // [RULE5]
    refreshFlag_q)
    else $error("refresh flag dropped early");
  refreshClear_a: assert property (refreshAge_q == 5'(FLAG_LIFE_CYCLES + 1) |-> !refreshFlag_q) // [RULE5] [RULE16]
    else $error("refresh flag outlived its window");
  startClear_a: assert property (startAge_q == 5'(FLAG_LIFE_CYCLES + 1) |-> !startFlag_q) // [RULE8]
    else $error("start flag outlived its window");
  startRuns_a: assert property (startSet && !wdResetReq_q |=> wdRunning) // [RULE6]
    else $error("start did not run watchdog");
  reloadLoad_a: assert property (startSet && refreshFlag_q && !wdResetReq_q |=>
    wdCount_q == {1'b0, $past(reloadVal_q), 8'h00}) // [RULE7]
    else $error("refresh did not reload counter");
  expiryReset_a: assert property (wdRunning && wdCount_q == WD_EXPIRE_VALUE && !wdResetReq_q |=> // [RULE9]
    wdResetReq && expiredStatus_q)
    else $error("expiry did not raise reset and status");
  statusKeep_a: assert property (wdResetReq_q |=> expiredStatus_q ##1 !wdRunning) // [RULE10]
    else $error("status lost across internal reset");
  noStop_a: assert property (wdRunning && !wdResetReq_q |=> wdRunning) // [RULE15]
    else $error("watchdog stopped without reset");
  missNoLoad_a: assert property (missed |=> !refreshFlag_q && irqStatus_q[IRQ_MISSED] && !irqStatus_q[IRQ_REFRESHED]
    || $past(irqStatus_q[IRQ_REFRESHED])) // [RULE16]
    else $error("missed window handled wrongly");

  expiryCover_c:  cover property (wdResetReq_q);
  reloadCover_c:  cover property (reload && wdRunning);
  missedCover_c:  cover property (missed);
  blockedCover_c: cover property (!globalEn_q && |srcReq && |{en1Src_q, en0Src_q});

endmodule

// File: rtl/wd_int_pkg.sv
// Register map, field layout and timing constants for the interrupt enable and soft watchdog block
package wd_int_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_WD_RELOAD  = 8'h86;
  localparam logic [7:0] IDX_INT_EN_PRI = 8'hA8;
  localparam logic [7:0] IDX_INT_PRI0   = 8'hA9;
  localparam logic [7:0] IDX_INT_EN_SEC = 8'hB8;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hC0;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'hC1;
  localparam logic [7:0] IDX_WD_COUNT   = 8'hC2;
  localparam logic [7:0] IDX_NONE       = 8'h00;

  // Reset values
  localparam logic [7:0] RST_WD_RELOAD  = 8'h00;
  localparam logic [7:0] RST_INT_EN_PRI = 8'h00;
  localparam logic [7:0] RST_INT_PRI0   = 8'h00;
  localparam logic [7:0] RST_INT_EN_SEC = 8'h00;
  localparam logic [2:0] RST_IRQ        = 3'h0;
  localparam logic [15:0] RST_WD_COUNT  = 16'h0000;

  // Field positions
  localparam int EN0_GLOBAL_BIT  = 7;
  localparam int EN0_REFRESH_BIT = 6;
  localparam int EN0_SRC_LSB     = 0;
  localparam int EN0_SRC_W       = 5;
  localparam int EN1_START_BIT   = 6;
  localparam int EN1_SRC_LSB     = 1;
  localparam int EN1_SRC_W       = 5;
  localparam int PRI0_STATUS_BIT = 6;
  localparam int PRI0_PRIO_W     = 6;
  localparam int RELOAD_PSEL_BIT = 7;
  localparam int RELOAD_VAL_W    = 7;

  // Interrupt status and mask layout
  localparam int IRQ_W         = 3;
  localparam int IRQ_EXPIRED   = 0;
  localparam int IRQ_REFRESHED = 1;
  localparam int IRQ_MISSED    = 2;

  // Source vector: ext0, tmr0, ext1, tmr1, ser0, ext2..ext6
  localparam int NUM_SRC = 10;

  // Timing counts in core clock cycles
  localparam int FLAG_LIFE_CYCLES = 12;
  localparam int WD_FAST_DIV      = 24;
  localparam int WD_SLOW_DIV      = 384;
  localparam logic [15:0] WD_EXPIRE_VALUE = 16'h7CFF;

  // Watchdog run state
  typedef enum logic [1:0] {
    WD_STOPPED = 2'b01,
    WD_RUNNING = 2'b10
  } wd_state_t;

endpackage

// File: rtl/wd_tick_gen.sv
// Watchdog prescaler producing one count tick every fast or slow division period
`timescale 1ns/1ps
module wd_tick_gen
  import wd_int_pkg::*;
#(
  parameter int FAST_DIV = WD_FAST_DIV,
  parameter int SLOW_DIV = WD_SLOW_DIV
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clear,
  input  wire logic run,
  input  wire logic slowSel,
  output logic      tick
);
  localparam int CW = $clog2(SLOW_DIV);

  logic [CW-1:0] divCnt_q;
  logic [CW-1:0] divLast;
  logic          slowSel_q;
  logic          armed_q;
  logic [CW-1:0] gap_q;

  // Extra divide-by-16 stage folded into the slow period
  assign divLast = slowSel ? CW'(SLOW_DIV - 1) : CW'(FAST_DIV - 1); // [RULE11] [RULE13]
  assign tick    = run && (divCnt_q == divLast);

  // Prescale counter, restarted on clear or when stopped
  always_ff @(posedge ref_clk) begin
    if (rst || clear || !run) begin
      divCnt_q <= '0;
    end else if (tick || divCnt_q > divLast) begin
      divCnt_q <= '0; // [RULE13]
    end else begin
      divCnt_q <= divCnt_q + CW'(1);
    end
  end

  // Helper: spacing between ticks with a steady selection
  always_ff @(posedge ref_clk) begin
    slowSel_q <= slowSel;
    if (rst || clear || !run || slowSel != slowSel_q) begin
      armed_q <= 1'b0;
      gap_q   <= '0;
    end else if (tick) begin
      armed_q <= 1'b1;
      gap_q   <= '0;
    end else begin
      gap_q <= gap_q + CW'(1);
    end
  end

  tickSpacing_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE13]
    tick && armed_q && slowSel == slowSel_q |-> gap_q == (slowSel ? CW'(SLOW_DIV - 1) : CW'(FAST_DIV - 1)))
    else $error("watchdog tick spacing wrong");
  slowCover_c: cover property (@(posedge ref_clk) disable iff (rst) tick && armed_q && slowSel);

endmodule

// File: verification/testbench.sv
// Self-checking testbench for the interrupt enable and soft watchdog block
`timescale 1ns/1ps
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin errors++; $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  import wd_int_pkg::*;
  localparam int FDIV = 4;
  localparam int SDIV = 64;

  logic               ref_clk = 1'b0;
  logic               rst     = 1'b1;
  logic               hsel    = 1'b0;
  logic [31:0]        haddr   = 32'h0000_0000;
  logic [1:0]         htrans  = 2'h0;
  logic               hwrite  = 1'b0;
  logic [2:0]         hsize   = 3'h2;
  logic [31:0]        hwdata  = 32'h0000_0000;
  logic               hready;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  logic [NUM_SRC-1:0] srcReq  = '0;
  logic [NUM_SRC-1:0] srcGranted;
  logic               wdResetReq;
  logic               irq;
  int                 errors;
  int                 checkCount;

  assign hready = hreadyout;

  int_enable_soft_watchdog_ctrl #(.FAST_DIV(FDIV), .SLOW_DIV(SDIV)) dut (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hwdata     (hwdata),
    .hready     (hready),
    .hrdata     (hrdata),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .srcReq     (srcReq),
    .srcGranted (srcGranted),
    .wdResetReq (wdResetReq),
    .irq        (irq)
  );

  // Clock generation, 8 ns period
  always #4 ref_clk = ~ref_clk;

  // Single AHB-Lite write: address phase, then data phase
  task automatic bus_wr(input logic [7:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    hsize  <= 3'h2;
    haddr  <= {22'h0, idx, 2'h0};
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
  endtask

  // Single AHB-Lite read, data taken at the data phase edge
  task automatic bus_rd(input logic [7:0] idx, output logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    hsize  <= 3'h2;
    haddr  <= {22'h0, idx, 2'h0};
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    do @(posedge ref_clk); while (hready !== 1'b1);
    d = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  // Read and compare against the model value
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(idx, d);
    `CHK(d, exp)
  endtask

  task automatic conclude;
    $display("Checks %0d, errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    conclude();
  end

  // Main sequence
  initial begin
    logic [31:0] e0, e1, r, c0, c1;
    logic [NUM_SRC-1:0] g;
    int n;
    errors = 0;
    checkCount = 0;
    void'($urandom(73511));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);

    // Reset values, plain storage and unmapped places
    rdc(IDX_WD_RELOAD, 32'h0000_0000);
    rdc(IDX_INT_EN_PRI, 32'h0000_0000);
    rdc(IDX_INT_PRI0, 32'h0000_0000);
    rdc(IDX_INT_EN_SEC, 32'h0000_0000);
    rdc(IDX_WD_COUNT, 32'h0000_0000);
    bus_wr(IDX_INT_PRI0, 32'h0000_003F);
    rdc(IDX_INT_PRI0, 32'h0000_003F);
    bus_wr(IDX_INT_PRI0, 32'h0000_0000);
    bus_wr(IDX_NONE, 32'h0000_00FF);
    rdc(IDX_NONE, 32'h0000_0000);
    rdc(8'h90, 32'h0000_0000);
    $display("Test reset values done");

    // Source gating with random enables and requests
    for (int i = 0; i < 24; i++) begin
      e0 = $urandom & 32'h0000_009F;
      if (i < 4) e0 = e0 & 32'h0000_001F;
      e1 = $urandom & 32'h0000_003E;
      bus_wr(IDX_INT_EN_PRI, e0);
      bus_wr(IDX_INT_EN_SEC, e1);
      r = $urandom;
      srcReq <= r[NUM_SRC-1:0];
      repeat (2) @(posedge ref_clk);
      g = r[NUM_SRC-1:0] & {e1[5:1], e0[4:0]} & {NUM_SRC{e0[7]}};
      `CHK(srcGranted, g)
      if (i == 5) begin
        rdc(IDX_INT_EN_PRI, e0);
        rdc(IDX_INT_EN_SEC, e1);
      end
    end
    bus_wr(IDX_INT_EN_PRI, 32'h0000_0000);
    bus_wr(IDX_INT_EN_SEC, 32'h0000_0000);
    $display("Test source gating done");

    // Refresh window missed while stopped
    bus_wr(IDX_IRQ_MASK, 32'h0000_0000);
    bus_wr(IDX_INT_EN_PRI, 32'h0000_0040);
    rdc(IDX_INT_EN_PRI, 32'h0000_0040);
    repeat (14) @(posedge ref_clk);
    rdc(IDX_INT_EN_PRI, 32'h0000_0000);
    `CHK(irq, 1'b0)
    bus_wr(IDX_IRQ_MASK, 32'h0000_0004);
    @(posedge ref_clk);
    `CHK(irq, 1'b1)
    rdc(IDX_IRQ_STATUS, 32'h0000_0004);
    `CHK(irq, 1'b0)
    rdc(IDX_WD_COUNT, 32'h0000_0000);
    rdc(IDX_IRQ_MASK, 32'h0000_0004);
    $display("Test missed refresh done");

    // Start, fast and slow rates, no stop by software
    bus_wr(IDX_INT_EN_SEC, 32'h0000_0040);
    rdc(IDX_INT_EN_SEC, 32'h0000_0040);
    bus_rd(IDX_WD_COUNT, c0);
    repeat (398) @(posedge ref_clk);
    bus_rd(IDX_WD_COUNT, c1);
    `CHK((c1 - c0) inside {[99:101]}, 1'b1)
    rdc(IDX_INT_EN_SEC, 32'h0000_0000);
    bus_wr(IDX_INT_EN_SEC, 32'h0000_0000);
    bus_wr(IDX_WD_RELOAD, 32'h0000_0080);
    bus_rd(IDX_WD_COUNT, c0);
    repeat (638) @(posedge ref_clk);
    bus_rd(IDX_WD_COUNT, c1);
    `CHK((c1 - c0) inside {[9:11]}, 1'b1)
    $display("Test count rates done");

    // Refresh sequence reloads high byte, clears low byte
    bus_wr(IDX_WD_RELOAD, 32'h0000_0055);
    bus_wr(IDX_INT_EN_PRI, 32'h0000_0040);
    bus_wr(IDX_INT_EN_SEC, 32'h0000_0040);
    bus_rd(IDX_WD_COUNT, c0);
    `CHK(c0[15:8], 8'h55)
    `CHK(c0[7:0] <= 8'h01, 1'b1)
    rdc(IDX_INT_EN_PRI, 32'h0000_0000);
    rdc(IDX_IRQ_STATUS, 32'h0000_0002);
    $display("Test refresh done");

    // Expiry, internal reset and surviving status
    bus_wr(IDX_IRQ_MASK, 32'h0000_0001);
    bus_wr(IDX_INT_PRI0, 32'h0000_0015);
    bus_wr(IDX_WD_RELOAD, 32'h0000_007C);
    bus_wr(IDX_INT_EN_PRI, 32'h0000_0040);
    bus_wr(IDX_INT_EN_SEC, 32'h0000_0040);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wdResetReq !== 1'b1 && n < 1300);
    `CHK(n inside {[1010:1030]}, 1'b1)
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    rdc(IDX_INT_PRI0, 32'h0000_0040);
    rdc(IDX_INT_EN_PRI, 32'h0000_0000);
    rdc(IDX_WD_RELOAD, 32'h0000_0000);
    rdc(IDX_WD_COUNT, 32'h0000_0000);
    rdc(IDX_IRQ_STATUS, 32'h0000_0003);
    `CHK(irq, 1'b0)
    rdc(IDX_IRQ_MASK, 32'h0000_0001);
    bus_wr(IDX_INT_PRI0, 32'h0000_0000);
    rdc(IDX_INT_PRI0, 32'h0000_0000);
    $display("Test expiry done");
    conclude();
  end
endmodule
